/* ladder_reference_control.sv */
// Purpose: apb register block and control for the 16-tap ladder reference.
// Assumes: analog inputs arrive digitised in 1/96 supply units, asynchronous.
// Notes:   sleep wake is not a reset here, so registers simply hold.
`timescale 1ns/10ps
`include "lrc_defs.svh"
module ladder_reference_control (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic [7:0]            pin_level_a0,
    input  wire logic [7:0]            pin_level_a1,
    input  wire logic [7:0]            pin_level_a2,
    input  wire logic [7:0]            pin_level_a3,
    output lrc_pkg::lrc_ladder_t       ladder,
    output logic                       ladder_power_on,
    output logic                       ref_pin_drive,
    output logic [7:0]                 ref_level,
    output lrc_pkg::lrc_cmp_sel_t      cmp_sel,
    output logic                       comparator1_result,
    output logic                       comparator2_result
);
    import lrc_pkg::*;

    localparam logic [9:0] IDX_CMP    = {2'b00, `LRC_IDX_CMP_CTRL};
    localparam logic [9:0] IDX_DIR    = {2'b00, `LRC_IDX_PORTA_DIR};
    localparam logic [9:0] IDX_LADDER = {2'b00, `LRC_IDX_LADDER_CTRL};
    localparam logic [9:0] IDX_LEVEL  = {2'b00, `LRC_IDX_LEVEL};

    // registers
    logic [7:0]   ladder_reg;
    logic [7:0]   ladder_next;
    logic [7:0]   cmp_reg;
    logic [7:0]   cmp_next;
    logic [7:0]   dir_reg;
    logic [7:0]   dir_next;
    logic [31:0]  prdata_reg;
    logic [31:0]  prdata_next;
    logic         pready_reg;
    logic         pready_next;
    logic         pslverr_reg;
    logic         pslverr_next;
    lrc_ladder_t  ladder_out_reg;
    lrc_ladder_t  ladder_out_next;
    logic         drive_reg;
    logic         drive_next;
    logic [7:0]   level_reg;
    lrc_cmp_sel_t cmp_sel_reg;
    lrc_cmp_sel_t cmp_sel_next;

    // pin input synchronisers, two flops per bit
    logic [31:0]  pins_meta_reg;
    logic [31:0]  pins_sync_reg;

    logic [9:0]   word_idx;
    logic         access_phase;
    logic         addr_ok;
    lrc_ladder_t  ladder_now;
    logic [7:0]   level_now;
    logic [7:0]   a0_s;
    logic [7:0]   a1_s;
    logic [7:0]   a2_s;
    logic [7:0]   a3_s;
    logic [7:0]   c1_pos;
    logic [7:0]   c1_neg;
    logic [7:0]   c2_pos;
    logic [7:0]   c2_neg;
    logic         c1_res;
    logic         c2_res;

    assign word_idx     = paddr[11:2];
    assign access_phase = psel && penable && !pready_reg;
    assign addr_ok      = (word_idx == IDX_CMP) || (word_idx == IDX_DIR) ||
                          (word_idx == IDX_LADDER) || (word_idx == IDX_LEVEL);

    // settings taken straight from the control register only
    assign ladder_now = '{power_on:  ladder_reg[`LRC_BIT_POWER],
                          pin_drive: ladder_reg[`LRC_BIT_PIN_DRIVE],
                          range_low: ladder_reg[`LRC_BIT_RANGE_LOW],
                          tap_code:  ladder_reg[3:0]};

    lrc_level_calc u_level (
        .ladder      (ladder_now),
        .level_96ths (level_now)
    );

    assign a0_s = pins_sync_reg[7:0];
    assign a1_s = pins_sync_reg[15:8];
    assign a2_s = pins_sync_reg[23:16];
    assign a3_s = pins_sync_reg[31:24];

    // mode 010 puts the reference on both noninverting inputs; otherwise
    // a simple pin pairing stands in for the other modes
    always_comb begin
        if (cmp_reg[2:0] == `LRC_MODE_INT_REF) begin
            c1_pos = level_reg;
            c2_pos = level_reg;
            c1_neg = cmp_reg[`LRC_BIT_INPUT_SWITCH] ? a3_s : a0_s;
            c2_neg = cmp_reg[`LRC_BIT_INPUT_SWITCH] ? a2_s : a1_s;
        end else begin
            c1_pos = a3_s;
            c2_pos = a2_s;
            c1_neg = a0_s;
            c2_neg = a1_s;
        end
    end

    lrc_comparator u_cmp1 (
        .pclk               (pclk),
        .presetn            (presetn),
        .noninverting_input (c1_pos),
        .inverting_input    (c1_neg),
        .result             (c1_res)
    );

    lrc_comparator u_cmp2 (
        .pclk               (pclk),
        .presetn            (presetn),
        .noninverting_input (c2_pos),
        .inverting_input    (c2_neg),
        .result             (c2_res)
    );

    // apb slave: one wait state, so pready rises the second access cycle
    always_comb begin
        ladder_next  = ladder_reg;
        cmp_next     = cmp_reg;
        dir_next     = dir_reg;
        prdata_next  = prdata_reg;
        pready_next  = 1'b0;
        pslverr_next = 1'b0;
        if (access_phase) begin
            pready_next  = 1'b1;
            pslverr_next = !addr_ok;
            prdata_next  = 32'h0000_0000;
            if (pwrite) begin
                unique case (word_idx)
                    IDX_LADDER: ladder_next = pwdata[7:0] & `LRC_LADDER_WMASK;
                    IDX_CMP:    cmp_next = (cmp_reg & ~`LRC_CMP_WMASK)
                                           | (pwdata[7:0] & `LRC_CMP_WMASK);
                    IDX_DIR:    dir_next = pwdata[7:0] & `LRC_PORTA_WMASK;
                    default:    ;
                endcase
            end else begin
                unique case (word_idx)
                    IDX_LADDER: prdata_next = {24'h00_0000, ladder_reg & `LRC_LADDER_WMASK};
                    IDX_CMP:    prdata_next = {24'h00_0000, c2_res, c1_res, 2'b00, cmp_reg[3:0]};
                    IDX_DIR:    prdata_next = {24'h00_0000, dir_reg};
                    IDX_LEVEL:  prdata_next = {24'h00_0000, level_reg};
                    default:    prdata_next = 32'h0000_0000;
                endcase
            end
        end
    end

    // outputs are registered from the next register image, so they move with the registers; the write data is
    // used directly so the ladder moves on the edge that raises pready
    always_comb begin
        ladder_out_next.power_on  = ladder_next[`LRC_BIT_POWER];
        ladder_out_next.pin_drive = ladder_next[`LRC_BIT_PIN_DRIVE];
        ladder_out_next.range_low = ladder_next[`LRC_BIT_RANGE_LOW];
        ladder_out_next.tap_code  = ladder_next[3:0];
        drive_next = ladder_next[`LRC_BIT_PIN_DRIVE] &&
                     dir_next[`LRC_BIT_DIR_PIN2];
        cmp_sel_next.noninv_is_ref = (cmp_next[2:0] == `LRC_MODE_INT_REF);
        cmp_sel_next.input_switch  = cmp_next[`LRC_BIT_INPUT_SWITCH];
        cmp_sel_next.config_mode   = cmp_next[2:0];
    end

    // only the device reset loads their reset values (8'h1F for the direction, zero elsewhere); there is no sleep input at all,
    // so a wake leaves every bit where software put it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ladder_reg     <= `LRC_RST_LADDER_CTRL;
            cmp_reg        <= `LRC_RST_CMP_CTRL;
            dir_reg        <= `LRC_RST_PORTA_DIR;
            prdata_reg     <= 32'h0000_0000;
            pready_reg     <= 1'b0;
            pslverr_reg    <= 1'b0;
            ladder_out_reg <= '0;
            drive_reg      <= 1'b0;
            level_reg      <= 8'h00;
            cmp_sel_reg    <= '0;
            pins_meta_reg  <= 32'h0000_0000;
            pins_sync_reg  <= 32'h0000_0000;
        end else begin
            ladder_reg     <= ladder_next;
            cmp_reg        <= cmp_next;
            dir_reg        <= dir_next;
            prdata_reg     <= prdata_next;
            pready_reg     <= pready_next;
            pslverr_reg    <= pslverr_next;
            ladder_out_reg <= ladder_out_next;
            drive_reg      <= drive_next;
            level_reg      <= level_now;
            cmp_sel_reg    <= cmp_sel_next;
            pins_meta_reg  <= {pin_level_a3, pin_level_a2, pin_level_a1, pin_level_a0};
            pins_sync_reg  <= pins_meta_reg;
        end
    end

    assign prdata             = prdata_reg;
    assign pready             = pready_reg;
    assign pslverr            = pslverr_reg;
    assign ladder             = ladder_out_reg;
    assign ladder_power_on    = ladder_out_reg.power_on;
    assign ref_pin_drive      = drive_reg;
    assign ref_level          = level_reg;
    assign cmp_sel            = cmp_sel_reg;
    assign comparator1_result = c1_res;
    assign comparator2_result = c2_res;
endmodule : ladder_reference_control

/* lrc_defs.svh */
// Purpose: offsets, field positions, reset values and write masks of the ladder reference.
// Assumes: 32-bit apb data, each register in one aligned word, data in the low byte.
// Notes:   offsets 0x1F and 0x85 are not multiples of four, so offsets are indices.
`ifndef LRC_DEFS_SVH
`define LRC_DEFS_SVH

`define LRC_IDX_CMP_CTRL     8'h1F
`define LRC_IDX_PORTA_DIR    8'h85
`define LRC_IDX_LADDER_CTRL  8'h9F
`define LRC_IDX_LEVEL        8'hA0

`define LRC_RST_CMP_CTRL     8'h00
`define LRC_RST_PORTA_DIR    8'h1F
`define LRC_RST_LADDER_CTRL  8'h00

`define LRC_LADDER_WMASK     8'hEF
`define LRC_CMP_WMASK        8'h0F
`define LRC_PORTA_WMASK      8'h1F

`define LRC_BIT_POWER        7
`define LRC_BIT_PIN_DRIVE    6
`define LRC_BIT_RANGE_LOW    5
`define LRC_BIT_DIR_PIN2     2
`define LRC_BIT_INPUT_SWITCH 3

`define LRC_MODE_INT_REF     3'h2
`define LRC_LOW_DENOM        8'h18
`define LRC_HIGH_DENOM       8'h20

`endif

/* lrc_pkg.sv */
// Purpose: types shared by the ladder reference control files.
// Assumes: none.
// Notes:   level fractions are in 1/96 supply units, the lcm of 24 and 32.
package lrc_pkg;
    typedef struct packed {
        logic       power_on;
        logic       pin_drive;
        logic       range_low;
        logic [3:0] tap_code;
    } lrc_ladder_t;

    typedef struct packed {
        logic       noninv_is_ref;
        logic       input_switch;
        logic [2:0] config_mode;
    } lrc_cmp_sel_t;
endpackage : lrc_pkg

/* lrc_level_calc.sv */
// Purpose: digital level of the ladder tap in 1/96 supply units.
// Assumes: ladder settings from registers on the same clock.
// Notes:   zero while powered down; the analog ladder itself lives outside.
`timescale 1ns/10ps
module lrc_level_calc (
    input  wire lrc_pkg::lrc_ladder_t ladder,
    output logic [7:0]                level_96ths
);
    import lrc_pkg::*;

    always_comb begin
        if (!ladder.power_on) begin
            level_96ths = 8'h00;
        end else if (ladder.range_low) begin
            level_96ths = {4'h0, ladder.tap_code} * 8'h04;
        end else begin
            level_96ths = 8'h18 + {4'h0, ladder.tap_code} * 8'h03;
        end
    end
endmodule : lrc_level_calc

/* lrc_comparator.sv */
// Purpose: one comparator decision from digitised input levels.
// Assumes: inputs already settled on the clock domain.
// Notes:   equal inputs keep the previous result rather than chatter.
`timescale 1ns/10ps
module lrc_comparator (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [7:0] noninverting_input,
    input  wire logic [7:0] inverting_input,
    output logic            result
);
    logic result_reg;
    logic result_next;

    always_comb begin
        result_next = result_reg;
        if (noninverting_input > inverting_input) begin
            result_next = 1'b1;
        end else if (noninverting_input < inverting_input) begin
            result_next = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_reg <= 1'b0;
        end else begin
            result_reg <= result_next;
        end
    end

    assign result = result_reg;
endmodule : lrc_comparator

/* lrc_asserts.sv */
// Purpose: concurrent checks on the ladder reference control ports.
// Assumes: one clock, async active-low reset, one apb wait state.
// Notes:   level figures in 1/96 supply units, one edge behind the ladder.
`timescale 1ns/10ps
module lrc_asserts (
    input logic                 pclk,
    input logic                 presetn,
    input logic                 psel,
    input logic                 penable,
    input logic                 pwrite,
    input logic [11:0]          paddr,
    input logic [31:0]          pwdata,
    input logic                 pready,
    input logic                 pslverr,
    input lrc_pkg::lrc_ladder_t ladder,
    input logic                 ladder_power_on,
    input logic                 ref_pin_drive,
    input logic [7:0]           ref_level,
    input lrc_pkg::lrc_cmp_sel_t cmp_sel,
    input logic                 comparator1_result
);
    import lrc_pkg::*;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_pin_gate: assert property (ref_pin_drive |-> ladder.pin_drive)
        else $error("pin driven without drive bit");
    a_power_copy: assert property (ladder_power_on == ladder.power_on)
        else $error("power output differs from power bit");
    a_level_low: assert property ($past(ladder.power_on & ladder.range_low)
        |-> ref_level == {2'h0, $past(ladder.tap_code), 2'h0})
        else $error("low range level wrong");
    a_level_high: assert property ($past(ladder.power_on & !ladder.range_low)
        |-> ref_level == 8'h18 + 8'h03 * {4'h0, $past(ladder.tap_code)})
        else $error("high range level wrong");
    a_level_off: assert property (!$past(ladder.power_on) |-> ref_level == 8'h00)
        else $error("level nonzero while powered down");
    a_ready_wait: assert property (psel && !penable ##1 psel && penable
        |-> !pready ##1 pready)
        else $error("access not ended after one wait state");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_ladder_write: assert property (psel && penable && pready && pwrite
        && paddr == 12'h27C |=> ladder == {$past(pwdata[7:5]), $past(pwdata[3:0])})
        else $error("ladder write not applied");
    a_ladder_hold: assert property ($changed(ladder) |-> $past(psel && penable && pwrite))
        else $error("ladder changed without a write");

    c_error_resp: cover property (pready && pslverr);
    c_pin_drive: cover property (ref_pin_drive);
    c_ref_compare: cover property (cmp_sel.noninv_is_ref && comparator1_result);
endmodule : lrc_asserts

/* tb_ladder_reference_control.sv */
// Purpose: self-checking bench for the ladder reference control block.
// Assumes: apb master waits for pready; byte address is four times the index.
// Notes:   pins a2/a3 stay low; mode 010 is probed with a0 and a1 equal.
`timescale 1ns/10ps
module tb_ladder_reference_control;
    import lrc_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, ladder_power_on, ref_pin_drive, c1, c2;
    logic [7:0] a0 = 8'h00, a1 = 8'h00, ref_level;
    lrc_ladder_t ladder;
    lrc_cmp_sel_t cmp_sel;
    int failures = 0, comparisons = 0, cycles = 0;

    ladder_reference_control DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_level_a0(a0),
        .pin_level_a1(a1), .pin_level_a2(8'h00), .pin_level_a3(8'h00),
        .ladder(ladder), .ladder_power_on(ladder_power_on), .ref_pin_drive(ref_pin_drive),
        .ref_level(ref_level), .cmp_sel(cmp_sel), .comparator1_result(c1),
        .comparator2_result(c2));

    always #25 pclk = ~pclk;
    // a hang in any wait ends here rather than running forever
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            end_of_test();
        end
    end

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic err);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    task automatic rchk(input logic [11:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, x);
        chk({31'h0, e}, 32'h0);
    endtask : rchk

    task automatic t_reset_values;
        rchk(12'h07C, 32'h00);
        rchk(12'h214, 32'h1F);
        rchk(12'h27C, 32'h00);
        wr(12'h27C, 32'hFF);
        rchk(12'h27C, 32'hEF);
    endtask : t_reset_values

    task automatic t_levels;
        logic [3:0] t;
        logic [7:0] e;
        for (int i = 0; i < 32; i++) begin
            t = i[3:0];
            e = i[4] ? {2'h0, t, 2'h0} : 8'h18 + 8'h03 * {4'h0, t};
            wr(12'h27C, {24'h0, 2'b10, i[4], 1'b0, t});
            repeat (3) @(posedge pclk);
            chk({24'h0, ref_level}, {24'h0, e});
            chk({25'h0, ladder}, {25'h0, 2'b10, i[4], t});
        end
        wr(12'h27C, 32'h2F);
        repeat (3) @(posedge pclk);
        chk({24'h0, ref_level}, 32'h0);
        chk({31'h0, ladder_power_on}, 32'h0);
    endtask : t_levels

    task automatic t_pin;
        wr(12'h27C, 32'hC0);
        repeat (2) @(posedge pclk);
        chk({31'h0, ref_pin_drive}, 32'h1);
        wr(12'h214, 32'h1B);
        repeat (2) @(posedge pclk);
        chk({31'h0, ref_pin_drive}, 32'h0);
        wr(12'h214, 32'h1F);
        wr(12'h27C, 32'h80);
        repeat (2) @(posedge pclk);
        chk({31'h0, ref_pin_drive}, 32'h0);
    endtask : t_pin

    task automatic t_compare;
        logic [31:0] r;
        logic e;
        wr(12'h27C, 32'hA6);
        wr(12'h07C, 32'h02);
        rchk(12'h27C, 32'hA6);
        rchk(12'h280, 32'h18);
        chk({27'h0, cmp_sel}, 32'h12);
        a0 <= 8'h0A; a1 <= 8'h0A;
        repeat (8) @(posedge pclk);
        chk({30'h0, c1, c2}, 32'h3);
        a0 <= 8'h28; a1 <= 8'h28;
        repeat (8) @(posedge pclk);
        chk({30'h0, c1, c2}, 32'h0);
        wr(12'h07C, 32'h0A);
        repeat (8) @(posedge pclk);
        chk({27'h0, cmp_sel}, 32'h1A);
        chk({30'h0, c1, c2}, 32'h3);
        apb(1'b0, 12'h000, 32'h0, r, e);
        chk({e, r[30:0]}, 32'h80000000);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        rchk(12'h27C, 32'h00);
    endtask : t_compare

    task end_of_test;
        if (failures == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_of_test

    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_reset_values();
        t_levels();
        t_pin();
        t_compare();
        end_of_test();
    end
endmodule : tb_ladder_reference_control

bind ladder_reference_control lrc_asserts u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .ladder(ladder), .ladder_power_on(ladder_power_on),
    .ref_pin_drive(ref_pin_drive), .ref_level(ref_level), .cmp_sel(cmp_sel),
    .comparator1_result(comparator1_result));
